// >>> spt_xlate.sv
// Segment descriptor registers, their move instructions and page entry matching with a TLB.
//
// What this block does
// RULE1 - Sixteen 32-bit segment descriptors, chosen by the effective address segment number.
// RULE2 - With direct-store bit clear, the descriptor holds the segment id in bits 8-31.
// RULE3 - The descriptor's segment id forms the upper part of the virtual page number.
// RULE4 - Each descriptor supplies supervisor key, user key and no-execute to protection.
// RULE5 - Separate instruction and data descriptor copies always receive identical writes.
// RULE6 - Move-to writes the source register; indirect form selects by index bits 0-3.
// RULE7 - Move-from reads a descriptor; indirect form selects by index bits 0-3.
// RULE8 - All four descriptor moves execute only in supervisor mode.
// RULE9 - On 64-bit parts without bridge support the moves raise illegal instruction.
// RULE10 - Page entries are 128 bits in 64-bit mode and 64 bits in 32-bit mode.
// RULE11 - An entry matches only if segment id, hash id, valid and page index agree.
// RULE12 - The TLB is searched first; a hit needs no page table search.
// RULE13 - Software invalidates TLB entries after changing the page table.
// RULE14 - 64-bit first doubleword: segment id 0-51, index 52-56, hash 62, valid 63.
// RULE15 - 64-bit second doubleword: page 0-51, R 55, C 56, mode 57-60, protection 62-63.
// RULE16 - 32-bit first word: valid 0, segment id 1-24, hash 25, index 26-31.
// RULE17 - 32-bit second word: page 0-19, R 23, C 24, mode 25-28, protection 30-31.
// RULE18 - 64-bit abbreviated index omits the 11 low page index bits.
// RULE19 - 32-bit abbreviated index omits the ten low page index bits.
// RULE20 - The four cache mode bits of the match steer accesses to that page.
// RULE21 - Address bits 0-3 pick the segment, 4-19 page index, 20-31 byte offset.
// RULE22 - A descriptor with direct-store bit set is not used for page translation.
// RULE23 - An entry or cached translation with valid clear never matches.
`timescale 1ns/1ps
module spt_xlate #(
	parameter int TLB_ENTRIES = 4
) (
	input  wire logic                 clk_sys,
	input  wire logic                 rst,
	input  wire logic                 mode64,
	input  wire logic                 bridge_en,
	input  wire logic                 supervisor,
	input  wire spt_pkg::spt_mv_req_t mv_req,
	output logic                      mv_done,
	output logic [31:0]               mv_data,
	output logic                      mv_priv_exc,
	output logic                      mv_illegal_exc,
	input  wire logic                 xl_req,
	input  wire logic [31:0]          xl_ea,
	input  wire logic                 xl_fetch,
	input  wire logic                 tlb_inval,
	output logic                      xl_busy,
	output logic                      xl_done,
	output spt_pkg::spt_fault_t       xl_fault,
	output logic [63:0]               xl_paddr,
	output logic [3:0]                xl_cache_mode_bits,
	output logic [1:0]                xl_page_protection_bits,
	output spt_pkg::spt_keys_t        xl_keys,
	output logic                      xl_referenced,
	output logic                      xl_changed,
	output logic                      pt_req,
	output logic [51:0]               pt_virtual_segment_id,
	output logic [15:0]               pt_pidx,
	input  wire logic                 pte_valid,
	input  wire logic                 pte_hash,
	input  wire logic                 pte_last,
	input  wire logic [127:0]         pte_data
);

	localparam int TW = (TLB_ENTRIES > 1) ? $clog2(TLB_ENTRIES) : 1;

	// Unpacks either entry format into one record.
	function automatic spt_pkg::spt_pte_t decode_pte(input logic m64, input logic [127:0] w);
		spt_pkg::spt_pte_t p;
		p = '0;
		if (m64) begin
			p.valid                = w[64+spt_pkg::P64_V_BIT]; // RULE14
			p.virtual_segment_id                 = w[64+spt_pkg::P64_VIRTUAL_SEGMENT_ID_LSB +: spt_pkg::P64_VIRTUAL_SEGMENT_ID_W];
			p.hash_id              = w[64+spt_pkg::P64_H_BIT];
			p.abbreviated_page_index                  = {1'b0, w[64+spt_pkg::P64_API_LSB +: spt_pkg::P64_API_W]};
			p.physical_page_number                  = w[spt_pkg::P64_RPN_LSB +: spt_pkg::P64_RPN_W]; // RULE15
			p.referenced           = w[spt_pkg::P64_R_BIT];
			p.changed              = w[spt_pkg::P64_C_BIT];
		end else begin
			p.valid                = w[32+spt_pkg::P32_V_BIT]; // RULE16
			p.virtual_segment_id                 = {28'h0, w[32+spt_pkg::P32_VIRTUAL_SEGMENT_ID_LSB +: spt_pkg::SD_VIRTUAL_SEGMENT_ID_W]};
			p.hash_id              = w[32+spt_pkg::P32_H_BIT];
			p.abbreviated_page_index                  = w[32+spt_pkg::P32_API_LSB +: spt_pkg::P32_API_W];
			p.physical_page_number                  = {32'h0, w[spt_pkg::P32_RPN_LSB +: spt_pkg::P32_RPN_W]}; // RULE17
			p.referenced           = w[spt_pkg::P32_R_BIT];
			p.changed              = w[spt_pkg::P32_C_BIT];
		end
		p.cache_mode_bits      = w[spt_pkg::CACHE_MODE_BITS_LSB +: spt_pkg::CACHE_MODE_BITS_W];
		p.page_protection_bits = w[spt_pkg::PP_LSB +: spt_pkg::PP_W];
		return p;
	endfunction : decode_pte

	// Descriptor copies and move unit state.
	logic [spt_pkg::SR_COUNT-1:0][31:0] sr_i_q, sr_i_d, sr_d_q, sr_d_d;
	logic        mv_done_q, mv_done_d, mv_priv_q, mv_priv_d, mv_ill_q, mv_ill_d;
	logic [31:0] mv_data_q, mv_data_d;
	logic [3:0]  mv_sel;
	logic        mv_illegal, mv_ok, mv_is_mt;

	// Move unit: the illegal check outranks the privilege check, since it holds in any mode.
	always_comb begin
		sr_i_d    = sr_i_q;
		sr_d_d    = sr_d_q;
		mv_sel    = mv_req.op[0] ? mv_req.index_gpr[spt_pkg::IDX_SEL_LSB +: spt_pkg::SR_SEL_W]
		                         : mv_req.sr_num; // RULE6 RULE7
		mv_is_mt  = ~mv_req.op[1];
		mv_illegal = mode64 & ~bridge_en; // RULE9
		mv_ok     = ~mv_illegal & supervisor; // RULE8
		mv_done_d = mv_req.valid;
		mv_ill_d  = mv_req.valid & mv_illegal;
		mv_priv_d = mv_req.valid & ~mv_illegal & ~supervisor;
		mv_data_d = 32'h0000_0000;
		if (mv_req.valid && mv_ok) begin
			if (mv_is_mt) begin
				sr_i_d[mv_sel] = mv_req.source_gpr; // RULE5 RULE6
				sr_d_d[mv_sel] = mv_req.source_gpr; // RULE5
			end else begin
				mv_data_d = sr_d_q[mv_sel]; // RULE7
			end
		end
	end

	// Descriptors clear at reset; software loads them before enabling translation.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sr_i_q    <= {spt_pkg::SR_COUNT{spt_pkg::SD_RESET}}; // RULE1
			sr_d_q    <= {spt_pkg::SR_COUNT{spt_pkg::SD_RESET}};
			mv_done_q <= 1'b0;
			mv_priv_q <= 1'b0;
			mv_ill_q  <= 1'b0;
			mv_data_q <= 32'h0000_0000;
		end else begin
			sr_i_q    <= sr_i_d;
			sr_d_q    <= sr_d_d;
			mv_done_q <= mv_done_d;
			mv_priv_q <= mv_priv_d;
			mv_ill_q  <= mv_ill_d;
			mv_data_q <= mv_data_d;
		end
	end

	assign mv_done        = mv_done_q;
	assign mv_data        = mv_data_q;
	assign mv_priv_exc    = mv_priv_q;
	assign mv_illegal_exc = mv_ill_q;

	// Translation state.
	spt_pkg::spt_state_t st_q, st_d;
	spt_pkg::spt_tlb_t [TLB_ENTRIES-1:0] tlb_q, tlb_d;
	logic [TW-1:0] fill_q, fill_d;
	logic [31:0]   ea_q, ea_d, sd_q, sd_d;
	logic          busy_d, done_q, done_d, preq_q, preq_d, ref_q, ref_d, chg_q, chg_d;
	spt_pkg::spt_fault_t fault_q, fault_d;
	logic [63:0]   pa_q, pa_d;
	logic [3:0]    cache_mode_bits_q, cache_mode_bits_d;
	logic [1:0]    pp_q, pp_d;
	spt_pkg::spt_keys_t keys_q, keys_d;
	logic          busy_q;
	logic [51:0]   cur_virtual_segment_id;
	logic [15:0]   cur_pidx;
	logic [5:0]    cur_api;
	logic [TLB_ENTRIES-1:0] tlb_hit;
	logic [TW-1:0] hit_idx;
	spt_pkg::spt_pte_t page_table_entry;
	logic          pte_match;

	// Virtual page number is the descriptor segment id above the address page index.
	assign cur_virtual_segment_id = {28'h0, sd_q[spt_pkg::SD_VIRTUAL_SEGMENT_ID_LSB +: spt_pkg::SD_VIRTUAL_SEGMENT_ID_W]}; // RULE2 RULE3
	assign cur_pidx = ea_q[spt_pkg::EA_PIDX_LSB +: spt_pkg::PIDX_W]; // RULE21
	assign cur_api  = mode64 ? {1'b0, cur_pidx[spt_pkg::PIDX_W-1 -: spt_pkg::P64_API_W]} // RULE18
	                         : cur_pidx[spt_pkg::PIDX_W-1 -: spt_pkg::P32_API_W]; // RULE19
	assign page_table_entry      = decode_pte(mode64, pte_data); // RULE10
	// Hash id is compared against the group that the walker reports it fetched from.
	assign pte_match = page_table_entry.valid & (page_table_entry.virtual_segment_id == cur_virtual_segment_id) & (page_table_entry.hash_id == pte_hash)
	                 & (page_table_entry.abbreviated_page_index == cur_api); // RULE11 RULE23

	// TLB compare, one comparator per entry; an invalid entry never hits.
	for (genvar g = 0; g < TLB_ENTRIES; g++) begin : g_tlb
		assign tlb_hit[g] = tlb_q[g].valid & (tlb_q[g].virtual_segment_id == cur_virtual_segment_id)
		                  & (tlb_q[g].pidx == cur_pidx); // RULE12 RULE23
	end

	// Lowest hitting entry; fills never create duplicates so at most one hits.
	always_comb begin
		hit_idx = '0;
		for (int i = TLB_ENTRIES - 1; i >= 0; i--) begin
			if (tlb_hit[i]) begin
				hit_idx = TW'(i);
			end
		end
	end

	// Translation sequencer: capture, TLB probe, then walk entries from memory.
	always_comb begin
		st_d    = st_q;
		tlb_d   = tlb_q;
		fill_d  = fill_q;
		ea_d    = ea_q;
		sd_d    = sd_q;
		done_d  = 1'b0;
		preq_d  = 1'b0;
		fault_d = fault_q;
		pa_d    = pa_q;
		cache_mode_bits_d  = cache_mode_bits_q;
		pp_d    = pp_q;
		keys_d  = keys_q;
		ref_d   = ref_q;
		chg_d   = chg_q;
		case (st_q)
			spt_pkg::SPT_S_IDLE: begin
				if (xl_req) begin
					ea_d = xl_ea;
					sd_d = xl_fetch ? sr_i_q[xl_ea[spt_pkg::EA_SEG_LSB +: spt_pkg::SR_SEL_W]]
					                : sr_d_q[xl_ea[spt_pkg::EA_SEG_LSB +: spt_pkg::SR_SEL_W]]; // RULE1
					st_d = spt_pkg::SPT_S_TLB;
				end
			end
			spt_pkg::SPT_S_TLB: begin
				keys_d = '{supervisor_key: sd_q[spt_pkg::SD_KS_BIT], // RULE4
				           user_key:       sd_q[spt_pkg::SD_KP_BIT],
				           no_exec:        sd_q[spt_pkg::SD_N_BIT]};
				if (sd_q[spt_pkg::SD_T_BIT]) begin
					done_d  = 1'b1; // RULE22
					fault_d = spt_pkg::SPT_F_DIRECT;
					st_d    = spt_pkg::SPT_S_IDLE;
				end else if (|tlb_hit) begin
					done_d  = 1'b1; // RULE12
					fault_d = spt_pkg::SPT_F_NONE;
					pa_d    = {tlb_q[hit_idx].physical_page_number[51:0], ea_q[spt_pkg::OFF_W-1:0]};
					cache_mode_bits_d  = tlb_q[hit_idx].cache_mode_bits;
					pp_d    = tlb_q[hit_idx].page_protection_bits;
					ref_d   = tlb_q[hit_idx].referenced;
					chg_d   = tlb_q[hit_idx].changed;
					st_d    = spt_pkg::SPT_S_IDLE;
				end else begin
					preq_d = 1'b1;
					st_d   = spt_pkg::SPT_S_PTE;
				end
			end
			spt_pkg::SPT_S_PTE: begin
				if (pte_valid && (pte_match || pte_last)) begin
					done_d  = 1'b1;
					st_d    = spt_pkg::SPT_S_IDLE;
					fault_d = pte_match ? spt_pkg::SPT_F_NONE : spt_pkg::SPT_F_MISS;
					if (pte_match) begin
						pa_d   = {page_table_entry.physical_page_number, ea_q[spt_pkg::OFF_W-1:0]}; // RULE21
						cache_mode_bits_d = page_table_entry.cache_mode_bits; // RULE20
						pp_d   = page_table_entry.page_protection_bits;
						ref_d  = page_table_entry.referenced;
						chg_d  = page_table_entry.changed;
						tlb_d[fill_q] = '{valid: 1'b1, virtual_segment_id: cur_virtual_segment_id, pidx: cur_pidx,
						                  physical_page_number: page_table_entry.physical_page_number, referenced: page_table_entry.referenced,
						                  changed: page_table_entry.changed,
						                  cache_mode_bits: page_table_entry.cache_mode_bits,
						                  page_protection_bits: page_table_entry.page_protection_bits};
						fill_d = (fill_q == TW'(TLB_ENTRIES - 1)) ? '0 : fill_q + 1'b1;
					end
				end
			end
			default: begin
				st_d = spt_pkg::SPT_S_IDLE;
			end
		endcase
		// Invalidation wins over a same-cycle fill so stale tables cannot linger.
		if (tlb_inval) begin
			for (int i = 0; i < TLB_ENTRIES; i++) begin
				tlb_d[i].valid = 1'b0; // RULE13
			end
		end
		busy_d = (st_d != spt_pkg::SPT_S_IDLE);
	end

	// Registers of the translation path.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_q    <= spt_pkg::SPT_S_IDLE;
			tlb_q   <= '0;
			fill_q  <= '0;
			ea_q    <= 32'h0000_0000;
			sd_q    <= 32'h0000_0000;
			busy_q  <= 1'b0;
			done_q  <= 1'b0;
			preq_q  <= 1'b0;
			fault_q <= spt_pkg::SPT_F_NONE;
			pa_q    <= 64'h0;
			cache_mode_bits_q  <= 4'h0;
			pp_q    <= 2'h0;
			keys_q  <= '0;
			ref_q   <= 1'b0;
			chg_q   <= 1'b0;
		end else begin
			st_q    <= st_d;
			tlb_q   <= tlb_d;
			fill_q  <= fill_d;
			ea_q    <= ea_d;
			sd_q    <= sd_d;
			busy_q  <= busy_d;
			done_q  <= done_d;
			preq_q  <= preq_d;
			fault_q <= fault_d;
			pa_q    <= pa_d;
			cache_mode_bits_q  <= cache_mode_bits_d;
			pp_q    <= pp_d;
			keys_q  <= keys_d;
			ref_q   <= ref_d;
			chg_q   <= chg_d;
		end
	end

	assign xl_busy                 = busy_q;
	assign xl_done                 = done_q;
	assign xl_fault                = fault_q;
	assign xl_paddr                = pa_q;
	assign xl_cache_mode_bits      = cache_mode_bits_q;
	assign xl_page_protection_bits = pp_q;
	assign xl_keys                 = keys_q;
	assign xl_referenced           = ref_q;
	assign xl_changed              = chg_q;
	assign pt_req                  = preq_q;
	// Search criteria stay valid while the walk is pending because ea_q and sd_q hold.
	assign pt_virtual_segment_id                 = cur_virtual_segment_id;
	assign pt_pidx                 = cur_pidx;

	// Checks.
	sequence s_mv_ok_mt;
		mv_req.valid && !(mode64 && !bridge_en) && supervisor && !mv_req.op[1];
	endsequence
	sequence s_tlb_probe_miss;
		st_q == spt_pkg::SPT_S_TLB && !sd_q[spt_pkg::SD_T_BIT] && !(|tlb_hit);
	endsequence

	copies_agree_a: assert property (@(posedge clk_sys) disable iff (rst) sr_i_q == sr_d_q) // RULE5
		else $error("Instruction and data descriptor copies differ.");
	mv_illegal_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE9
		mv_req.valid && mode64 && !bridge_en |=> mv_illegal_exc && mv_done && !mv_priv_exc
		&& $stable(sr_d_q))
		else $error("Move on 64-bit part without bridge did not fault.");
	mv_priv_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE8
		mv_req.valid && !(mode64 && !bridge_en) && !supervisor |=> mv_priv_exc
		&& mv_data == 32'h0 && $stable(sr_d_q))
		else $error("User-mode descriptor move was not refused.");
	mt_write_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE6
		s_mv_ok_mt ##0 mv_req.op[0] |=>
		sr_d_q[$past(mv_req.index_gpr[31:28])] == $past(mv_req.source_gpr))
		else $error("Indirect move-to wrote the wrong descriptor.");
	mf_read_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE7
		mv_req.valid && supervisor && !(mode64 && !bridge_en)
		&& mv_req.op == spt_pkg::SPT_MF_DIRECT |=> mv_data == $past(sr_d_q[mv_req.sr_num]))
		else $error("Direct move-from returned the wrong value.");
	direct_store_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE22
		st_q == spt_pkg::SPT_S_TLB && sd_q[spt_pkg::SD_T_BIT] |=>
		xl_done && xl_fault == spt_pkg::SPT_F_DIRECT && !pt_req)
		else $error("Direct-store segment was translated.");
	tlb_first_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE12
		st_q == spt_pkg::SPT_S_TLB && !sd_q[spt_pkg::SD_T_BIT] && (|tlb_hit) |=>
		xl_done && !pt_req && xl_fault == spt_pkg::SPT_F_NONE)
		else $error("TLB hit still started a table search.");
	miss_walk_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE12
		s_tlb_probe_miss |=> pt_req ##1 !pt_req)
		else $error("TLB miss did not start one table search.");
	valid_gate_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE23
		st_q == spt_pkg::SPT_S_PTE && pte_valid && !page_table_entry.valid |=>
		!(xl_done && xl_fault == spt_pkg::SPT_F_NONE))
		else $error("Invalid page entry reported as a match.");
	offset_pass_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE21
		xl_done && xl_fault == spt_pkg::SPT_F_NONE |-> xl_paddr[11:0] == ea_q[11:0])
		else $error("Byte offset not passed through.");

endmodule : spt_xlate

// >>> spt_pkg.sv
// Constants, field layouts and carrier types of the segment and page entry translation unit.
package spt_pkg;

	// Segment descriptor array and register layout (bit 0 of the text is the MSB here).
	localparam int SR_COUNT    = 16;
	localparam int SR_W        = 32;
	localparam int SR_SEL_W    = 4;
	localparam int SD_T_BIT    = 31;
	localparam int SD_KS_BIT   = 30;
	localparam int SD_KP_BIT   = 29;
	localparam int SD_N_BIT    = 28;
	localparam int SD_VIRTUAL_SEGMENT_ID_LSB = 0;
	localparam int SD_VIRTUAL_SEGMENT_ID_W   = 24;
	localparam logic [31:0] SD_RESET = 32'h0000_0000;
	localparam int IDX_SEL_LSB = 28;

	// Effective address split for 32-bit translation.
	localparam int EA_SEG_LSB  = 28;
	localparam int EA_PIDX_LSB = 12;
	localparam int PIDX_W      = 16;
	localparam int OFF_W       = 12;

	// 32-bit entry: word 0 in pte bits 63:32, word 1 in 31:0.
	localparam int P32_V_BIT     = 31;
	localparam int P32_VIRTUAL_SEGMENT_ID_LSB  = 7;
	localparam int P32_H_BIT     = 6;
	localparam int P32_API_LSB   = 0;
	localparam int P32_API_W     = 6;
	localparam int P32_HASH_BITS = 10;
	localparam int P32_RPN_LSB   = 12;
	localparam int P32_RPN_W     = 20;
	localparam int P32_R_BIT     = 8;
	localparam int P32_C_BIT     = 7;

	// 64-bit entry: doubleword 0 in pte bits 127:64, doubleword 1 in 63:0.
	localparam int P64_VIRTUAL_SEGMENT_ID_LSB  = 12;
	localparam int P64_VIRTUAL_SEGMENT_ID_W    = 52;
	localparam int P64_API_LSB   = 7;
	localparam int P64_API_W     = 5;
	localparam int P64_HASH_BITS = 11;
	localparam int P64_H_BIT     = 1;
	localparam int P64_V_BIT     = 0;
	localparam int P64_RPN_LSB   = 12;
	localparam int P64_RPN_W     = 52;
	localparam int P64_R_BIT     = 8;
	localparam int P64_C_BIT     = 7;

	// Fields at the same place in both second words.
	localparam int CACHE_MODE_BITS_LSB = 3;
	localparam int CACHE_MODE_BITS_W   = 4;
	localparam int PP_LSB   = 0;
	localparam int PP_W     = 2;
	localparam int API_W    = 6;

	typedef enum logic [1:0] {
		SPT_MT_DIRECT   = 2'h0,
		SPT_MT_INDIRECT = 2'h1,
		SPT_MF_DIRECT   = 2'h2,
		SPT_MF_INDIRECT = 2'h3
	} spt_sr_op_t;

	typedef enum logic [1:0] {
		SPT_F_NONE   = 2'h0,
		SPT_F_DIRECT = 2'h1,
		SPT_F_MISS   = 2'h2
	} spt_fault_t;

	typedef enum logic [2:0] {
		SPT_S_IDLE = 3'h1,
		SPT_S_TLB  = 3'h2,
		SPT_S_PTE  = 3'h4
	} spt_state_t;

	typedef struct packed {
		logic       valid;
		spt_sr_op_t op;
		logic [3:0] sr_num;
		logic [31:0] source_gpr;
		logic [31:0] index_gpr;
	} spt_mv_req_t;

	typedef struct packed {
		logic supervisor_key;
		logic user_key;
		logic no_exec;
	} spt_keys_t;

	typedef struct packed {
		logic        valid;
		logic [51:0] virtual_segment_id;
		logic        hash_id;
		logic [5:0]  abbreviated_page_index;
		logic [51:0] physical_page_number;
		logic        referenced;
		logic        changed;
		logic [3:0]  cache_mode_bits;
		logic [1:0]  page_protection_bits;
	} spt_pte_t;

	typedef struct packed {
		logic        valid;
		logic [51:0] virtual_segment_id;
		logic [15:0] pidx;
		logic [51:0] physical_page_number;
		logic        referenced;
		logic        changed;
		logic [3:0]  cache_mode_bits;
		logic [1:0]  page_protection_bits;
	} spt_tlb_t;

endpackage : spt_pkg

// >>> spt_pt_model.sv
// Behavioural page table in memory that offers candidate entries after each search request.
`timescale 1ns/1ps
module spt_pt_model (
	input  wire logic              clk_sys,
	input  wire logic              pt_req,
	input  wire logic [4:0][127:0] cand,
	input  wire logic [2:0]        n_cand,
	input  wire logic [3:0]        lag,
	input  wire logic              hash_sel,
	output logic                   pte_valid,
	output logic                   pte_hash,
	output logic                   pte_last,
	output logic [127:0]           pte_data,
	output logic                   pt_busy
);
	// One candidate a cycle after an optional lag; between offers the data bus shows
	// a changing pattern so that a design reading it at the wrong time sees garbage.
	initial begin
		pte_valid = 1'b0;
		pte_last  = 1'b0;
		pte_hash  = 1'b0;
		pte_data  = '0;
		pt_busy   = 1'b0;
		forever begin
			@(posedge clk_sys);
			if (pt_req === 1'b1) begin
				#1;
				pt_busy  = 1'b1;
				pte_hash = hash_sel;
				for (int i = 0; i < lag; i++) begin
					pte_data = ~pte_data;
					@(posedge clk_sys);
					#1;
				end
				for (int i = 0; i < n_cand; i++) begin
					pte_valid = 1'b1;
					pte_data  = cand[i];
					pte_last  = (i == n_cand - 1);
					@(posedge clk_sys);
					#1;
				end
				pte_valid = 1'b0;
				pte_last  = 1'b0;
				pte_data  = ~pte_data;
				pt_busy   = 1'b0;
			end
		end
	end
endmodule : spt_pt_model

// >>> spt_xlate_tb_top.sv
// Self-checking bench for the segment descriptor and page entry translation unit.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end
module spt_xlate_tb_top;
	logic                 clk_sys = 1'b0;
	logic                 rst = 1'b1;
	logic                 mode64 = 1'b0;
	logic                 bridge_en = 1'b0;
	logic                 supervisor = 1'b1;
	spt_pkg::spt_mv_req_t mv_req = '0;
	logic                 xl_req = 1'b0;
	logic [31:0]          xl_ea = 32'h0;
	logic                 xl_fetch = 1'b0;
	logic                 tlb_inval = 1'b0;
	logic                 mv_done, mv_priv_exc, mv_illegal_exc, xl_busy, xl_done;
	logic [31:0]          mv_data;
	spt_pkg::spt_fault_t  xl_fault;
	logic [63:0]          xl_paddr;
	logic [3:0]           xl_cache_mode_bits;
	logic [1:0]           xl_page_protection_bits;
	spt_pkg::spt_keys_t   xl_keys;
	logic                 xl_referenced, xl_changed, pt_req;
	logic [51:0]          pt_virtual_segment_id;
	logic [15:0]          pt_pidx;
	logic                 pte_valid, pte_hash, pte_last, pt_busy;
	logic [127:0]         pte_data;
	logic [4:0][127:0]    cand = '0;
	logic [2:0]           n_cand = 3'h0;
	logic [3:0]           lag = 4'h0;
	logic                 hash_sel = 1'b0;
	logic [31:0]          sd_m [16];
	logic [51:0]          g_rpn;
	logic [3:0]           g_cache_mode_bits;
	logic [1:0]           g_pp;
	logic                 g_r, g_c, g_m64;
	int                   errors = 0, n_tests = 0, seed = 32'h0456;

	// Clock at 25 MHz.
	always #20 clk_sys = ~clk_sys;

	spt_xlate dut (.clk_sys, .rst, .mode64, .bridge_en, .supervisor, .mv_req, .mv_done,
		.mv_data, .mv_priv_exc, .mv_illegal_exc, .xl_req, .xl_ea, .xl_fetch, .tlb_inval,
		.xl_busy, .xl_done, .xl_fault, .xl_paddr, .xl_cache_mode_bits, .xl_page_protection_bits,
		.xl_keys, .xl_referenced, .xl_changed, .pt_req, .pt_virtual_segment_id, .pt_pidx, .pte_valid,
		.pte_hash, .pte_last, .pte_data);

	spt_pt_model pt (.clk_sys, .pt_req, .cand, .n_cand, .lag, .hash_sel, .pte_valid,
		.pte_hash, .pte_last, .pte_data, .pt_busy);

	task automatic final_report;
		if (errors == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : final_report

	// Builds an entry in the layout of the current mode from the page fields in g_*.
	function automatic logic [127:0] page_table_entry(input logic v, h, input logic [51:0] vs,
		input logic [5:0] ap);
		if (g_m64) return {vs, ap[5:1], 5'h0, h, v,
			g_rpn, 3'h0, g_r, g_c, g_cache_mode_bits, 1'b0, g_pp};
		return {64'hc3c3_c3c3_c3c3_c3c3, v, vs[23:0], h, ap,
			g_rpn[19:0], 3'h0, g_r, g_c, g_cache_mode_bits, 1'b0, g_pp};
	endfunction : page_table_entry

	// One move; valid is held across back-to-back calls, so it is only raised when low.
	task automatic mv(input logic [1:0] op, input logic [3:0] sel, input logic [31:0] src);
		logic        ill, prv;
		logic [31:0] ex;
		ill = mode64 & ~bridge_en;
		prv = ~ill & ~supervisor;
		ex = (op[1] & ~ill & ~prv) ? sd_m[sel] : 32'h0;
		if (!op[1] && !ill && !prv) sd_m[sel] = src;
		mv_req.op = spt_pkg::spt_sr_op_t'(op);
		mv_req.sr_num = op[0] ? ~sel : sel;
		mv_req.index_gpr = {op[0] ? sel : ~sel, 28'($random(seed))};
		mv_req.source_gpr = src;
		if (mv_req.valid !== 1'b1) mv_req.valid = 1'b1;
		@(posedge clk_sys);
		#1;
		`CHK("mv_done", 1'b1, mv_done)
		`CHK("mv_data", ex, mv_data)
		`CHK("mv_priv_exc", prv, mv_priv_exc)
		`CHK("mv_illegal_exc", ill, mv_illegal_exc)
	endtask : mv

	task automatic mv_stop;
		mv_req.valid = 1'b0;
		@(posedge clk_sys);
		#1;
		`CHK("mv_done", 1'b0, mv_done)
	endtask : mv_stop

	// One translation; ns is the number of page table searches it should start.
	task automatic xl(input logic [31:0] ea, sd, input logic [1:0] fl, input int ns);
		int n;
		int np;
		logic [63:0] pa;
		n = 1;
		np = 0;
		xl_ea = ea;
		xl_fetch = 1'($random(seed));
		xl_req = 1'b1;
		@(posedge clk_sys);
		#1;
		xl_req = 1'b0;
		`CHK("xl_busy", 1'b1, xl_busy)
		while (xl_done !== 1'b1 && n < 40) begin
			if (pt_req === 1'b1) begin
				np++;
				`CHK("pt_virtual_segment_id", {28'h0, sd[23:0]}, pt_virtual_segment_id)
				`CHK("pt_pidx", ea[27:12], pt_pidx)
			end
			@(posedge clk_sys);
			#1;
			n++;
		end
		`CHK("xl_done", 1'b1, xl_done)
		`CHK("xl_fault", fl, xl_fault)
		`CHK("searches", ns, np)
		`CHK("xl_keys", sd[30:28], xl_keys)
		`CHK("xl_busy", 1'b0, xl_busy)
		if (ns == 0) `CHK("latency", 2, n)
		if (fl == 2'h0) begin
			pa = g_m64 ? {g_rpn, ea[11:0]} : {32'h0, g_rpn[19:0], ea[11:0]};
			`CHK("xl_paddr", pa, xl_paddr)
			`CHK("xl_cache_mode_bits", g_cache_mode_bits, xl_cache_mode_bits)
			`CHK("xl_page_protection_bits", g_pp, xl_page_protection_bits)
			`CHK("xl_ref_chg", {g_r, g_c}, {xl_referenced, xl_changed})
		end
		while (pt_busy === 1'b1) begin
			@(posedge clk_sys);
			#1;
		end
	endtask : xl

	// Miss, hit, invalidate and refill, low index bits, no match, and a direct-store segment.
	task automatic walk(input logic m64);
		logic [3:0]  sg;
		logic [31:0] sd, ea;
		logic [51:0] vs;
		logic [5:0]  ap;
		logic        h;
		sg = 4'($random(seed));
		sd = {1'b0, 3'($random(seed)), 4'h0, 24'($random(seed))};
		g_m64 = m64;
		mode64 = m64;
		bridge_en = m64;
		supervisor = 1'b1;
		mv(2'h0, sg, sd);
		mv(2'h1, sg ^ 4'h1, sd | 32'h8000_0000);
		mv_stop();
		ea = {sg, 28'($random(seed))};
		vs = {28'h0, sd[23:0]};
		ap = ea[27:22];
		h = 1'($random(seed));
		hash_sel = h;
		g_rpn = 52'({$random(seed), $random(seed)});
		{g_r, g_c, g_cache_mode_bits, g_pp} = 8'($random(seed));
		cand[0] = page_table_entry(1'b0, h, vs, ap);
		cand[1] = page_table_entry(1'b1, ~h, vs, ap);
		cand[2] = page_table_entry(1'b1, h, vs ^ 52'h1, ap);
		cand[3] = page_table_entry(1'b1, h, vs, ap ^ 6'h20);
		cand[4] = page_table_entry(1'b1, h, vs, ap);
		n_cand = 3'h5;
		lag = 4'($random(seed)) & 4'h3;
		xl(ea, sd, 2'h0, 1);
		xl(ea, sd, 2'h0, 0);
		tlb_inval = 1'b1;
		@(posedge clk_sys);
		#1;
		tlb_inval = 1'b0;
		g_cache_mode_bits = ~g_cache_mode_bits;
		cand[4] = page_table_entry(1'b1, h, vs, ap);
		xl(ea, sd, 2'h0, 1);
		xl(ea ^ 32'h0000_1000, sd, 2'h0, 1);
		n_cand = 3'h4;
		xl(ea ^ 32'h0000_2000, sd, 2'h2, 1);
		xl(ea ^ 32'h1000_0000, sd | 32'h8000_0000, 2'h1, 0);
	endtask : walk

	// Main sequence: random moves, a read of every descriptor, translations, second reset.
	initial begin
		for (int i = 0; i < 16; i++) sd_m[i] = 32'h0;
		repeat (5) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		`CHK("xl_fault", spt_pkg::SPT_F_NONE, xl_fault)
		for (int i = 0; i < 60; i++) begin
			mode64 = ($random(seed) & 7) == 0;
			bridge_en = 1'($random(seed));
			supervisor = ($random(seed) & 3) != 0;
			mv(2'(i), 4'($random(seed)), $random(seed));
		end
		mode64 = 1'b0;
		supervisor = 1'b1;
		for (int i = 0; i < 16; i++) mv(2'h3 - 2'(i & 1), 4'(i), 32'(i));
		mv_stop();
		for (int i = 0; i < 8; i++) walk(i >= 4);
		rst = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		mode64 = 1'b0;
		for (int i = 0; i < 16; i++) sd_m[i] = 32'h0;
		for (int i = 0; i < 16; i++) mv(2'h2, 4'(i), 32'h0);
		mv_stop();
		final_report();
	end

	// Watchdog: the run needs well under a thousand cycles.
	initial begin
		#(40 * 5000);
		errors++;
		final_report();
	end
endmodule : spt_xlate_tb_top
